// File: dv/adcs_chk.sv
// port assertions of the converter sequencer
module adcs_chk
  import adcs_pkg::*;
(
  input wire logic                clock,
  input wire logic                reset_n,
  input wire adcs_bus_t           bus,
  input wire logic [7:0]          rdata,
  input wire logic [NUM_PINS-1:0] pin_din,
  input wire logic [NUM_PINS-1:0] pin_digital_in,
  input wire logic [NUM_PINS-1:0] pin_buf_off,
  input wire adcs_ana_t           ana,
  input wire logic                conv_done_irq_flag,
  input wire logic                conv_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // write strobe to the main control register and its start request
  sequence s_wr_main;
    bus.wr && bus.addr == ADDR_CTRL_MAIN;
  endsequence
  sequence s_start;
    s_wr_main ##0 (bus.wdata[2] && bus.wdata[0] && !conv_busy);
  endsequence

  property p_rd_main;
    $past(bus.rd && bus.addr == ADDR_CTRL_MAIN) |-> !rdata[1];
  endproperty
  property p_rd_pins;
    $past(bus.rd && bus.addr == ADDR_PIN_SEL) |-> !rdata[7];
  endproperty
  property p_rd_aux;
    $past(bus.rd && bus.addr == ADDR_CTRL_AUX) |-> rdata[3:0] == 4'h0;
  endproperty
  property p_start;
    s_start ##0 ana.power |=> conv_busy;
  endproperty
  property p_no_start;
    s_start ##0 !ana.power |=> !conv_busy;
  endproperty
  property p_chan;
    s_wr_main |=> ana.channel == $past(bus.wdata[5:3]);
  endproperty
  property p_vref;
    bus.wr && bus.addr == ADDR_CTRL_AUX |=>
      ana.vref == $past(bus.wdata[5:4]);
  endproperty
  property p_buf;
    bus.wr && bus.addr == ADDR_PIN_SEL |=>
      pin_buf_off == $past(bus.wdata[6:0]);
  endproperty
  property p_din;
    pin_digital_in == ($past(pin_din, 2) & ~pin_buf_off);
  endproperty
  property p_flag_keep;
    conv_done_irq_flag && !(bus.wr && bus.addr == ADDR_FLAGS) |=>
      conv_done_irq_flag;
  endproperty
  property p_done;
    $rose(conv_done_irq_flag) && !$past(bus.wr && bus.addr == ADDR_FLAGS)
      |-> $fell(conv_busy);
  endproperty
  property p_abort;
    s_wr_main ##0 (!bus.wdata[2] && conv_busy && !conv_done_irq_flag)
      |=> !conv_busy && !conv_done_irq_flag;
  endproperty
  property p_off;
    s_wr_main ##0 !bus.wdata[0] |=> !ana.power && !conv_busy;
  endproperty

  a_rd_main: assert property (p_rd_main) else $error("bit1 nonzero");
  a_rd_pins: assert property (p_rd_pins) else $error("bit7 nonzero");
  a_rd_aux: assert property (p_rd_aux) else $error("aux low bits");
  a_start: assert property (p_start) else $error("no start");
  a_no_start: assert property (p_no_start) else $error("off start");
  a_chan: assert property (p_chan) else $error("channel wrong");
  a_vref: assert property (p_vref) else $error("vref wrong");
  a_buf: assert property (p_buf) else $error("buffer wrong");
  a_din: assert property (p_din) else $error("analog pin read");
  a_flag_keep: assert property (p_flag_keep) else $error("flag lost");
  a_done: assert property (p_done) else $error("flag no finish");
  a_abort: assert property (p_abort) else $error("abort failed");
  a_off: assert property (p_off) else $error("still powered");
endmodule

bind adcs_control adcs_chk u_chk (
  .clock              (clock),
  .reset_n            (reset_n),
  .bus                (bus),
  .rdata              (rdata),
  .pin_din            (pin_din),
  .pin_digital_in     (pin_digital_in),
  .pin_buf_off        (pin_buf_off),
  .ana                (ana),
  .conv_done_irq_flag (conv_done_irq_flag),
  .conv_busy          (conv_busy)
);

// File: dv/adcs_core_model.sv
// behavioural converter core: channel levels, comparator, rc source
module adcs_core_model
  import adcs_pkg::*;
(
  input  wire adcs_ana_t ana,
  output      logic      comp_hi,
  output      logic      rc_osc
);
  timeunit 1ns;
  timeprecision 1ns;

  // fixed level per channel
  function automatic logic [9:0] lvl(input logic [2:0] ch);
    return 10'h0a5 + 10'(ch) * 10'h091;
  endfunction

  assign comp_hi = ana.power && (lvl(ana.channel) >= ana.trial);

  initial begin
    rc_osc = 1'b0;
    forever #50 rc_osc = ~rc_osc;
  end
endmodule

// File: dv/tb_top.sv
// self-checking bench for the converter sequencer
module tb_top
  import adcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clock;
  logic       reset_n;
  adcs_bus_t  bus;
  logic [7:0] rdata;
  logic       sleep_mode;
  logic       rc_osc;
  logic       comp_hi;
  logic [6:0] pin_din;
  logic [6:0] pin_digital_in;
  logic [6:0] pin_buf_off;
  adcs_ana_t  ana;
  logic       conv_done_irq_flag;
  logic       conv_busy;
  logic [7:0] hi;
  logic [7:0] lo;
  int         mismatches;
  int         tests_run;
  int         cycles;

  adcs_control dut (
    .clock(clock), .reset_n(reset_n), .bus(bus), .rdata(rdata),
    .sleep_mode(sleep_mode), .rc_osc(rc_osc), .comp_hi(comp_hi),
    .pin_din(pin_din), .pin_digital_in(pin_digital_in),
    .pin_buf_off(pin_buf_off), .ana(ana),
    .conv_done_irq_flag(conv_done_irq_flag), .conv_busy(conv_busy)
  );
  adcs_core_model core (.ana(ana), .comp_hi(comp_hi), .rc_osc(rc_osc));

  // clock and hang guard
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle write and read strobes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus <= '{a, d, 1'b0, 1'b0};
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    bus <= '{a, 8'h00, 1'b0, 1'b0};
    #1;
    chk(16'(rdata), 16'(e));
  endtask

  // one conversion per clock setting, channel and alignment
  task automatic conv(input int i);
    logic [1:0] sel;
    logic [2:0] ch;
    logic       hv;
    logic       js;
    logic [9:0] r;
    int         dv;
    int         n;
    sel = (i < 6) ? 2'(i / 2) : 2'h3;
    ch  = 3'(i);
    hv  = i[0];
    js  = ~i[1];
    dv  = (2 << (2 * sel)) << hv;
    r   = 10'h0a5 + 10'(i) * 10'h091;
    wr(ADDR_CTRL_AUX, {js, hv, 2'(i), 4'h0});
    wr(ADDR_CTRL_MAIN, {sel, ch, 3'h1});
    repeat (20) @(posedge clock);
    chk(16'(ana.sample), 16'h1);
    chk(16'(ana.channel), 16'(ch));
    chk(16'(ana.vref), 16'(i % 4));
    wr(ADDR_CTRL_MAIN, {sel, ch, 3'h5});
    chk(16'({conv_busy, ana.sample}), 16'({1'b1, sel == 2'h3}));
    n = 0;
    if (sel == 2'h3) begin
      @(posedge clock) sleep_mode <= 1'b1;
      rd(ADDR_CTRL_MAIN, {sel, ch, 3'h5});
      n = 3;
    end
    while (conv_busy === 1'b1 && n < 2000) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (sel == 2'h3)
      chk(16'(n >= 104 && n <= 130), 16'h1);
    else
      chk(16'(n >= 11 * dv && n <= 11 * dv + 4), 16'h1);
    @(posedge clock) sleep_mode <= 1'b0;
    hi = js ? {6'h00, r[9:8]} : r[9:2];
    lo = js ? r[7:0] : {r[1:0], 6'h00};
    rd(ADDR_RES_HIGH, hi);
    rd(ADDR_RES_LOW, lo);
    rd(ADDR_FLAGS, 8'h01);
    wr(ADDR_FLAGS, 8'h00);
    repeat (2 * dv) @(posedge clock);
  endtask

  initial begin
    reset_n    = 1'b0;
    bus        = '{8'h00, 8'h00, 1'b0, 1'b0};
    sleep_mode = 1'b0;
    pin_din    = 7'h3c;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    chk(16'(pin_buf_off), 16'h007f);
    rd(ADDR_CTRL_AUX, 8'h00);
    rd(ADDR_PIN_SEL, 8'h7f);
    rd(ADDR_RES_HIGH, 8'h00);
    rd(ADDR_FLAGS, 8'h00);
    wr(ADDR_CTRL_MAIN, 8'h05);
    rd(ADDR_CTRL_MAIN, 8'h01);
    wr(ADDR_CTRL_MAIN, 8'h04);
    rd(ADDR_CTRL_MAIN, 8'h00);
    wr(ADDR_PIN_SEL, 8'hd5);
    rd(ADDR_PIN_SEL, 8'h55);
    repeat (4) @(posedge clock);
    chk(16'(pin_buf_off), 16'h0055);
    chk(16'(pin_digital_in), 16'h0028);
    wr(8'h40, 8'h5a);
    rd(8'h40, 8'h00);
    wr(ADDR_CTRL_AUX, 8'hff);
    rd(ADDR_CTRL_AUX, 8'hf0);
    wr(ADDR_CTRL_MAIN, 8'hfb);
    rd(ADDR_CTRL_MAIN, 8'hf9);
    wr(ADDR_PIN_SEL, 8'h7f);
    for (int i = 0; i < 7; i++)
      conv(i);
    // abort in mid conversion keeps the result
    wr(ADDR_CTRL_AUX, 8'h40);
    wr(ADDR_CTRL_MAIN, 8'h91);
    wr(ADDR_CTRL_MAIN, 8'h95);
    repeat (50) @(posedge clock);
    wr(ADDR_CTRL_MAIN, 8'h91);
    chk(16'(conv_busy), 16'h0);
    rd(ADDR_RES_HIGH, hi);
    rd(ADDR_RES_LOW, lo);
    rd(ADDR_FLAGS, 8'h00);
    repeat (128) @(posedge clock);
    // sleep on a system clock source
    wr(ADDR_CTRL_MAIN, 8'h95);
    repeat (50) @(posedge clock);
    sleep_mode <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk(16'({conv_busy, ana.power}), 16'h0);
    rd(ADDR_CTRL_MAIN, 8'h91);
    @(posedge clock) sleep_mode <= 1'b0;
    rd(ADDR_FLAGS, 8'h00);
    wr(ADDR_CTRL_MAIN, 8'h90);
    chk(16'(ana.power), 16'h0);
    print_verdict();
  end
endmodule

// File: logic/adcs_control.sv
// converter control sequencer: registers, pin select, start and result
//
// The implementer's own choice: strobed register access.
module adcs_control
  import adcs_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                reset_n,
  input  wire adcs_bus_t           bus,
  output      logic [7:0]          rdata,
  input  wire logic                sleep_mode,
  input  wire logic                rc_osc,
  input  wire logic                comp_hi,
  input  wire logic [NUM_PINS-1:0] pin_din,
  output      logic [NUM_PINS-1:0] pin_digital_in,
  output      logic [NUM_PINS-1:0] pin_buf_off,
  output      adcs_ana_t           ana,
  output      logic                conv_done_irq_flag,
  output      logic                conv_busy
);

  typedef enum logic [1:0] {CV_IDLE, CV_DELAY, CV_CONV} adcs_cv_t;

  // software-visible fields
  logic [1:0]          clk_sel_ff;
  logic [2:0]          channel_sel_ff;
  logic                conv_run_flag_ff;
  logic                converter_on_ff;
  logic                result_justify_ff;
  logic                clk_halve_sel_ff;
  logic [1:0]          vref_cfg_ff;
  logic [NUM_PINS-1:0] analog_select_bits_ff;
  logic [7:0]          result_high_byte_ff;
  logic [7:0]          result_low_byte_ff;
  logic                done_flag_ff;
  logic [7:0]          rdata_ff;

  // sequencing state
  adcs_cv_t            cv_state_ff;
  logic [2:0]          delay_ff;
  logic                comp_ff;
  logic [NUM_PINS-1:0] pin_sync0_ff;
  logic [NUM_PINS-1:0] pin_sync1_ff;

  // decoded strobes and events
  logic                wr_main;
  logic                wr_aux;
  logic                wr_pins;
  logic                wr_high;
  logic                wr_low;
  logic                wr_flags;
  logic                rc_mode;
  logic                sleep_kill;
  logic                go_req;
  logic                abort;
  logic                sar_start;
  logic                sar_done;
  logic                sar_busy;
  logic                sar_sample;
  logic [RES_BITS-1:0] sar_trial;
  logic [RES_BITS-1:0] sar_result;
  logic                tad_en;
  logic                finish;

  // address decode of one write strobe
  function automatic logic hit(adcs_bus_t b, logic [7:0] a);
    return b.wr & (b.addr == a);
  endfunction

  assign wr_main  = hit(bus, ADDR_CTRL_MAIN);
  assign wr_aux   = hit(bus, ADDR_CTRL_AUX);
  assign wr_pins  = hit(bus, ADDR_PIN_SEL);
  assign wr_high  = hit(bus, ADDR_RES_HIGH);
  assign wr_low   = hit(bus, ADDR_RES_LOW);
  assign wr_flags = hit(bus, ADDR_FLAGS);

  assign rc_mode = (clk_sel_ff == CLK_SEL_RC);

  assign sleep_kill = sleep_mode & ~rc_mode;

  assign go_req = wr_main & bus.wdata[MAIN_RUN_BIT] & converter_on_ff
                & bus.wdata[MAIN_ON_BIT] & ~conv_run_flag_ff & ~sleep_kill;

  // run cleared, power off or sleep abort
  assign abort = conv_run_flag_ff
               & ((wr_main & ~bus.wdata[MAIN_RUN_BIT])
                | (wr_main & ~bus.wdata[MAIN_ON_BIT])
                | sleep_kill);

  // conversion completes without a competing abort
  assign finish = sar_done & conv_run_flag_ff & ~abort;

  // comparator answers our own trial register: one settling stage
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      comp_ff <= 1'b0;
    end else begin
      comp_ff <= comp_hi; // two stages would miss a two-clock bit period
    end
  end

  // digital pin inputs are asynchronous: two stages
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_sync0_ff <= '0;
      pin_sync1_ff <= '0;
    end else begin
      pin_sync0_ff <= pin_din;
      pin_sync1_ff <= pin_sync0_ff;
    end
  end

  // per-pin function: analog pins read low on the digital side
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      assign pin_buf_off[gi]    = analog_select_bits_ff[gi];
      assign pin_digital_in[gi] = pin_sync1_ff[gi]
                                & ~analog_select_bits_ff[gi];
    end
  endgenerate

  // pin select register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      analog_select_bits_ff <= PIN_SEL_RST;
    end else if (wr_pins) begin
      analog_select_bits_ff <= bus.wdata[NUM_PINS-1:0];
    end
  end

  // main control fields except the run flag
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clk_sel_ff      <= CLK_SEL_RST;
      channel_sel_ff  <= CHAN_RST;
      converter_on_ff <= 1'b0;
    end else if (wr_main) begin
      clk_sel_ff      <= bus.wdata[MAIN_CLK_LSB +: 2];
      channel_sel_ff  <= bus.wdata[MAIN_CHAN_LSB +: 3];
      converter_on_ff <= bus.wdata[MAIN_ON_BIT];
    end
  end

  // aux control fields
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      result_justify_ff <= 1'b0;
      clk_halve_sel_ff  <= 1'b0;
      vref_cfg_ff       <= VREF_RST;
    end else if (wr_aux) begin
      result_justify_ff <= bus.wdata[AUX_JUST_BIT];
      clk_halve_sel_ff  <= bus.wdata[AUX_HALVE_BIT];
      vref_cfg_ff       <= bus.wdata[AUX_VREF_LSB +: 2];
    end
  end

  // run flag: set by start, cleared by finish or abort
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      conv_run_flag_ff <= 1'b0;
    end else if (go_req) begin
      conv_run_flag_ff <= 1'b1;
    end else if (finish || abort) begin
      conv_run_flag_ff <= 1'b0;
    end
  end

  // start path: rc source waits one instruction cycle first
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cv_state_ff <= CV_IDLE;
      delay_ff    <= 3'h0;
    end else if (abort) begin
      cv_state_ff <= CV_IDLE;
    end else begin
      case (cv_state_ff)
        CV_IDLE: begin
          if (go_req && rc_mode) begin
            cv_state_ff <= CV_DELAY;
            delay_ff    <= INSTR_CNT;
          end else if (go_req) begin
            cv_state_ff <= CV_CONV;
          end
        end
        CV_DELAY: begin
          if (delay_ff == 3'h0) begin
            cv_state_ff <= CV_CONV;
          end else begin
            delay_ff <= delay_ff - 3'h1;
          end
        end
        CV_CONV: begin
          if (sar_done) begin
            cv_state_ff <= CV_IDLE;
          end
        end
        default: cv_state_ff <= CV_IDLE;
      endcase
    end
  end

  // sequencer kicked when delay is over or at once on system clock
  assign sar_start = (cv_state_ff == CV_IDLE && go_req && !rc_mode)
                   | (cv_state_ff == CV_DELAY && delay_ff == 3'h0
                      && !abort);

  adcs_tad_gen u_tad (
    .clock         (clock),
    .reset_n       (reset_n),
    .restart       (sar_start),
    .clk_sel       (clk_sel_ff),
    .clk_halve_sel (clk_halve_sel_ff),
    .rc_osc        (rc_osc),
    .tad_en        (tad_en)
  );

  adcs_sar u_sar (
    .clock   (clock),
    .reset_n (reset_n),
    .start   (sar_start),
    .abort   (abort),
    .tad_en  (tad_en),
    .comp_hi (comp_ff),
    .busy    (sar_busy),
    .sample  (sar_sample),
    .trial   (sar_trial),
    .done    (sar_done),
    .result  (sar_result)
  );

  // result pair: loaded at finish, otherwise plain storage
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      result_high_byte_ff <= RES_RST;
      result_low_byte_ff  <= RES_RST;
    end else if (finish) begin
      if (result_justify_ff) begin
        result_high_byte_ff <= {6'h00, sar_result[9:8]};
        result_low_byte_ff  <= sar_result[7:0];
      end else begin
        result_high_byte_ff <= sar_result[9:2];
        result_low_byte_ff  <= {sar_result[1:0], 6'h00};
      end
    end else begin
      if (wr_high) begin
        result_high_byte_ff <= bus.wdata;
      end
      if (wr_low) begin
        result_low_byte_ff <= bus.wdata;
      end
    end
  end

  // completion flag: set wins over a software clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      done_flag_ff <= 1'b0;
    end else if (finish) begin
      done_flag_ff <= 1'b1;
    end else if (wr_flags) begin
      done_flag_ff <= bus.wdata[FLAG_DONE_BIT];
    end
  end

  // read data register, valid the cycle after the strobe
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        ADDR_CTRL_MAIN: rdata_ff <= {clk_sel_ff, channel_sel_ff,
                                     conv_run_flag_ff, 1'b0,
                                     converter_on_ff};
        ADDR_CTRL_AUX:  rdata_ff <= {result_justify_ff,
                                     clk_halve_sel_ff,
                                     vref_cfg_ff, 4'h0};
        ADDR_PIN_SEL:   rdata_ff <= {1'b0, analog_select_bits_ff};
        ADDR_RES_HIGH:  rdata_ff <= result_high_byte_ff;
        ADDR_RES_LOW:   rdata_ff <= result_low_byte_ff;
        ADDR_FLAGS:     rdata_ff <= {7'h00, done_flag_ff};
        default:        rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign rdata = rdata_ff;

  // converter core controls
  // power follows on bit, cleared by sleep on a system clock source
  // rc conversion keeps power in sleep
  assign ana.power   = converter_on_ff & ~sleep_kill;
  assign ana.sample  = sar_sample & converter_on_ff;
  assign ana.channel = channel_sel_ff;
  assign ana.vref    = vref_cfg_ff;
  assign ana.trial   = sar_trial;

  assign conv_done_irq_flag = done_flag_ff;
  assign conv_busy          = conv_run_flag_ff | sar_busy;

endmodule

// File: logic/adcs_sar.sv
// successive-approximation sequencer, one result bit per bit period
module adcs_sar
  import adcs_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                reset_n,
  input  wire logic                start,
  input  wire logic                abort,
  input  wire logic                tad_en,
  input  wire logic                comp_hi,
  output      logic                busy,
  output      logic                sample,
  output      logic [RES_BITS-1:0] trial,
  output      logic                done,
  output      logic [RES_BITS-1:0] result
);

  typedef enum logic [1:0] {SAR_IDLE, SAR_HOLD, SAR_BITS} adcs_sar_t;

  adcs_sar_t           state_ff;
  logic [RES_BITS-1:0] trial_ff;
  logic [RES_BITS-1:0] mask_ff;
  logic [RES_BITS-1:0] kept;

  // drop the trial bit when the input sits below it
  assign kept = comp_hi ? trial_ff : (trial_ff & ~mask_ff);

  // sequencer: hold segment, then one decision per bit period
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= SAR_IDLE;
      trial_ff <= '0;
      mask_ff  <= '0;
    end else if (abort) begin
      state_ff <= SAR_IDLE;
      trial_ff <= '0;
    end else begin
      case (state_ff)
        SAR_IDLE: begin
          if (start) begin
            state_ff <= SAR_HOLD;
            trial_ff <= '0;
          end
        end
        SAR_HOLD: begin
          if (tad_en) begin
            state_ff <= SAR_BITS;
            mask_ff  <= {1'b1, {(RES_BITS-1){1'b0}}};
            trial_ff <= {1'b1, {(RES_BITS-1){1'b0}}};
          end
        end
        SAR_BITS: begin
          if (tad_en) begin
            mask_ff  <= mask_ff >> 1;
            trial_ff <= kept | (mask_ff >> 1);
            if (mask_ff[0]) begin
              state_ff <= SAR_IDLE;
            end
          end
        end
        default: state_ff <= SAR_IDLE;
      endcase
    end
  end

  // completion pulse and final code
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      done   <= 1'b0;
      result <= '0;
    end else begin
      done <= ~abort & (state_ff == SAR_BITS) & tad_en & mask_ff[0];
      if ((state_ff == SAR_BITS) && tad_en && mask_ff[0]) begin
        result <= kept;
      end
    end
  end

  assign busy   = (state_ff != SAR_IDLE);
  assign sample = (state_ff == SAR_IDLE);
  assign trial  = trial_ff;

endmodule

// File: logic/adcs_tad_gen.sv
// bit period enable generator from system clock or rc source
module adcs_tad_gen
  import adcs_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       restart,
  input  wire logic [1:0] clk_sel,
  input  wire logic       clk_halve_sel,
  input  wire logic       rc_osc,
  output      logic       tad_en
);

  logic [2:0] rc_sync_ff;
  logic [6:0] count_ff;
  logic [6:0] divisor;
  logic       rc_rise;

  assign divisor = tad_divisor(clk_sel, clk_halve_sel);

  // rc source is asynchronous: two stages, then one for edge detect
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rc_sync_ff <= 3'h0;
    end else begin
      rc_sync_ff <= {rc_sync_ff[1:0], rc_osc};
    end
  end

  assign rc_rise = rc_sync_ff[1] & ~rc_sync_ff[2];

  // free divider, realigned at each conversion start
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_ff <= 7'h00;
    end else if (restart || divisor == 7'h00) begin
      count_ff <= 7'h00;
    end else if (count_ff >= divisor - 7'h01) begin
      count_ff <= 7'h00;
    end else begin
      count_ff <= count_ff + 7'h01;
    end
  end

  // one pulse per bit period
  assign tad_en = (divisor == 7'h00) ? rc_rise
                : (~restart & (count_ff == divisor - 7'h01));

endmodule

// File: shared/adcs_pkg.sv
// constants, field layouts and carrier types of the converter sequencer
package adcs_pkg;

  // register offsets on the register port
  localparam logic [7:0] ADDR_CTRL_MAIN = 8'h1f;
  localparam logic [7:0] ADDR_PIN_SEL   = 8'h9b;
  localparam logic [7:0] ADDR_CTRL_AUX  = 8'h9f;
  localparam logic [7:0] ADDR_RES_HIGH  = 8'h1e;
  localparam logic [7:0] ADDR_RES_LOW   = 8'h9e;
  localparam logic [7:0] ADDR_FLAGS     = 8'h0c;

  // field positions, main control
  localparam int MAIN_CLK_LSB  = 6;
  localparam int MAIN_CHAN_LSB = 3;
  localparam int MAIN_RUN_BIT  = 2;
  localparam int MAIN_ON_BIT   = 0;
  // field positions, aux control
  localparam int AUX_JUST_BIT  = 7;
  localparam int AUX_HALVE_BIT = 6;
  localparam int AUX_VREF_LSB  = 4;
  // field position, flag register
  localparam int FLAG_DONE_BIT = 0;

  // widths
  localparam int NUM_PINS = 7;
  localparam int RES_BITS = 10;

  // values after reset
  localparam logic [1:0]          CLK_SEL_RST  = 2'h0;
  localparam logic [2:0]          CHAN_RST     = 3'h0;
  localparam logic [1:0]          VREF_RST     = 2'h0;
  localparam logic [NUM_PINS-1:0] PIN_SEL_RST  = 7'h7f;
  localparam logic [7:0]          RES_RST      = 8'h00;

  // clock select code of the internal rc source
  localparam logic [1:0] CLK_SEL_RC = 2'h3;

  // timing: system clock and instruction cycle
  localparam int CLK_PERIOD_NS   = 10;
  localparam int INSTR_CYCLE_NS  = 40;
  localparam int INSTR_CLKS      =
    (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] INSTR_CNT = 3'(INSTR_CLKS - 1);

  // bit period in system clocks per clock select, zero means rc source
  function automatic logic [6:0] tad_divisor(logic [1:0] sel,
                                             logic       halve);
    logic [6:0] d;
    d = 7'h00;
    case (sel)
      2'h0:    d = halve ? 7'h04 : 7'h02;
      2'h1:    d = halve ? 7'h10 : 7'h08;
      2'h2:    d = halve ? 7'h40 : 7'h20;
      default: d = 7'h00;
    endcase
    return d;
  endfunction

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } adcs_bus_t;

  // controls toward the sample/hold converter core
  typedef struct packed {
    logic                power;
    logic                sample;
    logic [2:0]          channel;
    logic [1:0]          vref;
    logic [RES_BITS-1:0] trial;
  } adcs_ana_t;

endpackage
